//--- cfdcs_assertions.sv
// port checks for the clock supervisor
`timescale 1ns/1ns
module cfdcs_assertions
    import cfdcs_pkg::*;
#(
    parameter int unsigned WDOG_SHORT = 20
) (
    // clock and resets
    input wire logic           clk_in,
    input wire logic           rst_n_in,
    input wire logic           por_n_in,
    // inputs
    input wire logic           xtal_in,
    input wire logic           master_flag_in,
    input wire logic           repeater_flag_in,
    input wire cfdcs_rx_type   rx_in,
    input wire logic           regulated_out_pin_short_in,
    // outputs
    input wire logic           freq_16_out,
    input wire logic           chip_reset_out,
    input wire logic           inductor_off_out,
    input wire logic           analog_pd_out,
    input wire cfdcs_stat_type status_out
);
    logic       xtal_prev;
    logic [7:0] idle;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!por_n_in);
    // cycles since the crystal last changed
    always_ff @(posedge clk_in) begin
        xtal_prev <= xtal_in;
        if (!por_n_in || xtal_in != xtal_prev) begin
            idle <= 8'h00;
        end else if (idle != 8'hFF) begin
            idle <= idle + 8'h01;
        end
    end
    a_por_defaults: assert property (disable iff (1'b0) !por_n_in |=> freq_16_out && chip_reset_out)
        else $error("defaults missing during power-on reset");
    a_por_clears: assert property (disable iff (1'b0) !por_n_in |=> !status_out.locked && !status_out.protect)
        else $error("power-on reset left lock or protect set");
    a_lock_holds: assert property (status_out.locked |=> status_out.locked)
        else $error("lock dropped without power-on reset");
    a_freq_frozen: assert property (status_out.locked && $past(status_out.locked) |=> $stable(freq_16_out))
        else $error("frequency changed after lock");
    a_slave_refuse: assert property (!master_flag_in && !repeater_flag_in && rx_in == 2'b01
        && !status_out.locked |-> ##2 !status_out.locked)
        else $error("slave response locked in slave mode");
    a_call_locks: assert property (rst_n_in && rx_in.master_call && $past(por_n_in, 2) |-> ##2 status_out.locked)
        else $error("master call did not lock");
    a_wdog_reset: assert property (int'(idle) > WDOG_SHORT + 5 |-> chip_reset_out)
        else $error("stopped crystal gave no reset");
    a_short_trips: assert property ($rose(regulated_out_pin_short_in)
        |-> ##[1:8] (inductor_off_out && analog_pd_out && chip_reset_out))
        else $error("output short gave no protection");
    a_protect_latch: assert property (inductor_off_out && analog_pd_out |=> inductor_off_out && analog_pd_out)
        else $error("protection state released");
    // main scenarios reached
    c_lock_8: cover property (status_out.locked && !freq_16_out);
    c_protect: cover property (status_out.protect);
    c_wdog: cover property (int'(idle) > WDOG_SHORT + 5);
endmodule : cfdcs_assertions

bind cfdcs_supervisor cfdcs_assertions #(.WDOG_SHORT(WDOG_SHORT)) u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .por_n_in(por_n_in), .xtal_in(xtal_in), .master_flag_in(master_flag_in), .repeater_flag_in(repeater_flag_in),
    .rx_in(rx_in), .regulated_out_pin_short_in(regulated_out_pin_short_in), .freq_16_out(freq_16_out),
    .chip_reset_out(chip_reset_out), .inductor_off_out(inductor_off_out), .analog_pd_out(analog_pd_out),
    .status_out(status_out));

//--- cfdcs_pkg.sv
// constants and types for the crystal frequency detect and clock supervisor
// Functional notes
// - detect 8 or 16 MHz crystal and set internal clock generation to match
// - after one correctly received telegram, freeze detection result
// - only power-on reset releases the frozen frequency selection
// - in slave mode only a valid master call triggers the lock
// - master, repeater, monitor: master call or slave response triggers lock
// - after power-on reset run the 16 MHz setting by default
// - about 200 us after power-on reset switch to 8 MHz or stay at 16
// - no oscillation for 150 us asserts reset until oscillation returns
// - also force unconditional reset after about 20 us without oscillation
// - over 140 C for more than 2 s: inductor off, reset, analog power-down
// - overheat protection state is latched until bus supply is cycled
// - regulated output short to ground acts exactly like overheat; here it latches at once, no 2 s wait
// - master and repeater flags select mode, read at init, never switched online
package cfdcs_pkg;

    // timing figures in their own units
    localparam int unsigned CLK_MHZ           = 100;
    localparam int unsigned DETECT_TIME_US    = 200;
    localparam int unsigned WDOG_LONG_US      = 150;
    localparam int unsigned WDOG_SHORT_US     = 20;
    localparam int unsigned OVERHEAT_TIME_MS  = 2000;
    // derived cycle counts
    localparam int unsigned DETECT_CYCLES     = DETECT_TIME_US * CLK_MHZ;
    localparam int unsigned WDOG_LONG_CYCLES  = WDOG_LONG_US * CLK_MHZ;
    localparam int unsigned WDOG_SHORT_CYCLES = WDOG_SHORT_US * CLK_MHZ;
    localparam int unsigned OVERHEAT_CYCLES   = OVERHEAT_TIME_MS * 1000 * CLK_MHZ;
    // toggles counted over detect window: 16 MHz gives 6400, 8 MHz 3200
    localparam int unsigned XTAL_THRESH       = 4800;
    localparam int unsigned CNT_W             = 32;
    // frequency encoding
    localparam logic        FREQ_16           = 1'b1;
    localparam logic        FREQ_8            = 1'b0;

    // operating modes from master and repeater flags
    typedef enum logic [1:0] {
        CFDCS_SLAVE   = 2'h0,
        CFDCS_MONITOR = 2'h1,
        CFDCS_MASTER  = 2'h2,
        CFDCS_REPEAT  = 2'h3
    } cfdcs_mode_type;

    // telegram receive strobes
    typedef struct packed {
        logic master_call;
        logic slave_resp;
    } cfdcs_rx_type;

    // status toward the rest of the chip
    typedef struct packed {
        logic freq_16;
        logic locked;
        logic detect_done;
        logic protect;
    } cfdcs_stat_type;

endpackage : cfdcs_pkg

//--- cfdcs_supervisor.sv
// crystal frequency detection, lock, clock watchdog and protection latch
`timescale 1ns/1ns
module cfdcs_supervisor
    import cfdcs_pkg::*;
#(
    parameter int unsigned DETECT_CNT   = DETECT_CYCLES,
    parameter int unsigned WDOG_LONG    = WDOG_LONG_CYCLES,
    parameter int unsigned WDOG_SHORT   = WDOG_SHORT_CYCLES,
    parameter int unsigned OVERHEAT_CNT = OVERHEAT_CYCLES,
    parameter int unsigned THRESH       = XTAL_THRESH
) (
    // clock and resets
    input  wire logic           clk_in,
    input  wire logic           rst_n_in,
    input  wire logic           por_n_in,
    // crystal oscillator sense (asynchronous)
    input  wire logic           xtal_in,
    // stored mode flags
    input  wire logic           master_flag_in,
    input  wire logic           repeater_flag_in,
    // telegram receiver strobes (same clock)
    input  wire cfdcs_rx_type   rx_in,
    // analog alarms (asynchronous)
    input  wire logic           overtemp_in,
    input  wire logic           regulated_out_pin_short_in,
    // outputs
    output logic                freq_16_out,
    output logic                chip_reset_out,
    output logic                inductor_off_out,
    output logic                analog_pd_out,
    output cfdcs_stat_type      status_out
);
    // synchronisers: stage one read only by stage two
    logic [1:0] xtal_sync;
    logic [1:0] temp_sync;
    logic [1:0] short_sync;
    logic       xtal_last;

    // power-on state: only por_n_in clears it
    logic           freq_16;
    logic           locked;
    logic           detect_done;
    logic           protect;
    logic [CNT_W-1:0] edge_count;
    cfdcs_mode_type mode;
    logic           mode_loaded;

    // derived wires
    wire xtal_edge    = xtal_sync[1] ^ xtal_last;
    wire temp_hot     = temp_sync[1];
    wire short_seen   = short_sync[1];
    wire detect_end;
    wire wdog_long_hit;
    wire wdog_short_hit;
    wire overheat_hit;
    wire lock_trigger;
    wire next_freq_16;

    // slave needs a master call, other modes accept either
    assign lock_trigger = (mode == CFDCS_SLAVE) ? rx_in.master_call
                        : (rx_in.master_call || rx_in.slave_resp);
    // edge count over window decides the crystal rate
    assign next_freq_16 = (edge_count >= CNT_W'(THRESH));

    // input synchronisers
    always_ff @(posedge clk_in) begin
        if (!por_n_in) begin
            xtal_sync  <= 2'h0;
            temp_sync  <= 2'h0;
            short_sync <= 2'h0;
            xtal_last  <= 1'b0;
        end else begin
            xtal_sync  <= {xtal_sync[0], xtal_in};
            temp_sync  <= {temp_sync[0], overtemp_in};
            short_sync <= {short_sync[0], regulated_out_pin_short_in};
            xtal_last  <= xtal_sync[1];
        end
    end

    // detection window from power-on reset
    cfdcs_timer #(.LIMIT(DETECT_CNT)) u_detect (
        .clk_in      (clk_in),
        .rst_n_in    (por_n_in),
        .clear_in    (1'b0),
        .run_in      (!detect_done),
        .reached_out (detect_end)
    );

    // watchdog long timeout, cleared by every oscillator edge
    cfdcs_timer #(.LIMIT(WDOG_LONG)) u_wdog_long (
        .clk_in      (clk_in),
        .rst_n_in    (por_n_in),
        .clear_in    (xtal_edge),
        .run_in      (1'b1),
        .reached_out (wdog_long_hit)
    );

    // watchdog short timeout
    cfdcs_timer #(.LIMIT(WDOG_SHORT)) u_wdog_short (
        .clk_in      (clk_in),
        .rst_n_in    (por_n_in),
        .clear_in    (xtal_edge),
        .run_in      (1'b1),
        .reached_out (wdog_short_hit)
    );

    // overheat persistence; cleared whenever the die cools
    cfdcs_timer #(.LIMIT(OVERHEAT_CNT)) u_overheat (
        .clk_in      (clk_in),
        .rst_n_in    (por_n_in),
        .clear_in    (!temp_hot),
        .run_in      (1'b1),
        .reached_out (overheat_hit)
    );

    // mode flags captured once after power-on, never switched online
    always_ff @(posedge clk_in) begin
        if (!por_n_in) begin
            mode        <= CFDCS_SLAVE;
            mode_loaded <= 1'b0;
        end else if (!mode_loaded) begin
            mode        <= cfdcs_mode_type'({master_flag_in, repeater_flag_in});
            mode_loaded <= 1'b1;
        end
    end

    // oscillator edge counting during the window
    always_ff @(posedge clk_in) begin
        if (!por_n_in) begin
            edge_count <= '0;
        end else if (!detect_done && xtal_edge && !(&edge_count)) begin
            edge_count <= edge_count + CNT_W'(1);
        end
    end

    // frequency selection: 16 by default, decided at window end, frozen by lock
    always_ff @(posedge clk_in) begin
        if (!por_n_in) begin
            freq_16     <= FREQ_16;
            detect_done <= 1'b0;
        end else if (!locked && !detect_done && detect_end) begin
            freq_16     <= next_freq_16;
            detect_done <= 1'b1;
        end
    end

    // lock: set by qualified telegram, cleared only by power-on reset
    always_ff @(posedge clk_in) begin
        if (!por_n_in) begin
            locked <= 1'b0;
        end else if (lock_trigger && mode_loaded && rst_n_in) begin
            locked <= 1'b1;
        end
    end

    // protection latch: overheat or output short, held to power cycle
    always_ff @(posedge clk_in) begin
        if (!por_n_in) begin
            protect <= 1'b0;
        end else if (overheat_hit || short_seen) begin
            protect <= 1'b1;
        end
    end

    // registered outputs
    always_ff @(posedge clk_in) begin
        if (!por_n_in) begin
            freq_16_out      <= FREQ_16;
            chip_reset_out   <= 1'b1;
            inductor_off_out <= 1'b0;
            analog_pd_out    <= 1'b0;
            status_out       <= '0;
        end else begin
            freq_16_out      <= freq_16;
            // reset while clock missing (short figure covers the long one)
            chip_reset_out   <= wdog_short_hit || wdog_long_hit || protect || !rst_n_in;
            inductor_off_out <= protect;
            analog_pd_out    <= protect;
            status_out       <= '{freq_16: freq_16, locked: locked,
                                  detect_done: detect_done, protect: protect};
        end
    end
endmodule : cfdcs_supervisor

//--- cfdcs_timer.sv
// saturating cycle timer with clear and threshold flag
`timescale 1ns/1ns
module cfdcs_timer
    import cfdcs_pkg::*;
#(
    parameter int unsigned LIMIT = 16
) (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // control
    input  wire logic clear_in,
    input  wire logic run_in,
    // result
    output logic      reached_out
);
    logic [CNT_W-1:0] count;
    wire  [CNT_W-1:0] limit_w = CNT_W'(LIMIT);
    wire              at_limit = (count >= limit_w);

    // count while running, hold at limit
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || clear_in) begin
            count <= '0;
        end else if (run_in && !at_limit) begin
            count <= count + CNT_W'(1);
        end
    end

    // flag registered for clean output
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || clear_in) begin
            reached_out <= 1'b0;
        end else begin
            reached_out <= at_limit;
        end
    end
endmodule : cfdcs_timer

//--- cfdcs_xtal_model.sv
// crystal oscillator model, fast or scaled slow rate
`timescale 1ns/1ns
module cfdcs_xtal_model (
    // control
    input  wire logic run_in,
    input  wire logic slow_in,
    // oscillator sense
    output logic      xtal_out
);
    // fast rate reads above the scaled threshold, slow rate below it
    initial xtal_out = 1'b0;
    always begin
        #(slow_in ? 100 : 31);
        if (run_in) xtal_out = ~xtal_out;
    end
endmodule : cfdcs_xtal_model

//--- crystal_freq_detect_and_clock_supervisor_test.sv
// self-checking bench for the clock supervisor
`timescale 1ns/1ns
module crystal_freq_detect_and_clock_supervisor_test
    import cfdcs_pkg::*;
;
    localparam int DET = 200;
    localparam int WS = 20;
    localparam int OH = 50;
    logic clk_in = 1'b0, rst_n_in = 1'b0, por_n_in = 1'b0, mf = 1'b0, rf = 1'b0, ot = 1'b0, sh = 1'b0;
    logic run = 1'b1, slow = 1'b0, xtal, f16, crst, ind, apd, exp_lock;
    cfdcs_rx_type rx = '0;
    cfdcs_stat_type st;
    int errors = 0, check_count = 0, seed = 33, m;
    // clock and instances
    always #5 clk_in = ~clk_in;
    cfdcs_xtal_model xm (.run_in(run), .slow_in(slow), .xtal_out(xtal));
    cfdcs_supervisor #(.DETECT_CNT(DET), .WDOG_LONG(150), .WDOG_SHORT(WS), .OVERHEAT_CNT(OH), .THRESH(24)) dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .por_n_in(por_n_in), .xtal_in(xtal), .master_flag_in(mf),
        .repeater_flag_in(rf), .rx_in(rx), .overtemp_in(ot), .regulated_out_pin_short_in(sh),
        .freq_16_out(f16), .chip_reset_out(crst), .inductor_off_out(ind), .analog_pd_out(apd), .status_out(st));
    // helpers
    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask : tick
    task automatic chk(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic power_up(input logic [1:0] mode, input logic s);
        por_n_in = 1'b0;
        {mf, rf} = mode;
        slow = s;
        tick(2);
        por_n_in = 1'b1;
    endtask : power_up
    task automatic pulse(input cfdcs_rx_type v);
        rx = v;
        tick(1);
        rx = '0;
    endtask : pulse
    task automatic close_out();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    // hang guard
    initial begin
        #200000;
        errors++;
        close_out();
    end
    // test sequence
    initial begin
        tick(2);
        rst_n_in = 1'b1;
        for (m = 0; m < 4; m++) begin
            power_up(m[1:0], 1'b1);
            chk(f16, 1'b1);
            tick(3 + ($random(seed) & 7));
            pulse(2'b01);
            tick(4);
            exp_lock = (m != 0);
            chk(st.locked, exp_lock);
            tick(DET + 10);
            chk(f16, exp_lock);
            pulse(2'b10);
            tick(4);
            chk(st.locked, 1'b1);
            rst_n_in = 1'b0;
            tick(2);
            rst_n_in = 1'b1;
            tick(3);
            chk(st.locked, 1'b1);
            chk(f16, exp_lock);
            $display("mode test %0d done", m);
        end
        power_up(2'b00, 1'b0);
        tick(DET + 10);
        chk(f16, 1'b1);
        run = 1'b0;
        tick(WS + 10);
        chk(crst, 1'b1);
        run = 1'b1;
        tick(10);
        chk(crst, 1'b0);
        $display("watchdog test done");
        for (m = 0; m < 2; m++) begin
            power_up(2'b00, 1'b0);
            tick(5);
            {ot, sh} = m ? 2'b01 : 2'b10;
            tick(OH + 10);
            chk(ind & apd & crst & st.protect, 1'b1);
            {ot, sh} = 2'b00;
            tick(5);
            chk(ind & apd & st.protect, 1'b1);
            $display("alarm test %0d done", m);
        end
        power_up(2'b00, 1'b0);
        tick(5);
        chk(st.protect | ind, 1'b0);
        close_out();
    end
endmodule : crystal_freq_detect_and_clock_supervisor_test
